// file: core/ita_pkg.sv
// shared constants, types and strap decode for the two-address i2c target
package ita_pkg;
	// ********************************************************************
	// strap bands and address tables
	// ********************************************************************
	typedef logic [1:0] ita_band_type;
	typedef logic [6:0] ita_addr_type;

	localparam ita_band_type ITA_BAND_RESET   = 2'h0;
	localparam ita_addr_type ITA_PRI_P1_BASE  = 7'h20;
	localparam ita_addr_type ITA_PRI_P2_BASE  = 7'h24;
	localparam ita_addr_type ITA_SEC_ADDR_A   = 7'h38;
	localparam ita_addr_type ITA_SEC_ADDR_B   = 7'h3f;
	localparam ita_addr_type ITA_SEC_ADDR_C   = 7'h4f;
	localparam ita_addr_type ITA_SEC_ADDR_D   = 7'h48;
	localparam logic [2:0]   ITA_LAST_BIT     = 3'h7;
	localparam int           ITA_SYNC_STAGES  = 3;

	// ********************************************************************
	// carriers
	// ********************************************************************
	typedef struct packed {
		ita_addr_type mask;
		ita_addr_type value;
	} ita_fw_type;

	typedef struct packed {
		logic [7:0] data;
		logic       port;
		logic       sub;
	} ita_rx_type;

	// strap band to address for one interface and port, then firmware mask
	function automatic ita_addr_type ita_port_addr(input logic secondary,
		input logic port, input ita_band_type band, input ita_fw_type fw);
		ita_addr_type strap;
		strap = '0;
		if (!secondary) begin
			strap = (port ? ITA_PRI_P2_BASE : ITA_PRI_P1_BASE) | {5'h00, band};
		end else begin
			unique case (band)
				2'h0: strap = port ? ITA_SEC_ADDR_B : ITA_SEC_ADDR_A;
				2'h1: strap = port ? ITA_SEC_ADDR_A : ITA_SEC_ADDR_B;
				2'h2: strap = port ? ITA_SEC_ADDR_D : ITA_SEC_ADDR_C;
				2'h3: strap = port ? ITA_SEC_ADDR_C : ITA_SEC_ADDR_D;
			endcase
		end
		return (strap & ~fw.mask) | (fw.value & fw.mask);
	endfunction
endpackage

// file: core/ita_top.sv
// i2c target engine with clock stretching and strapped two-port addressing
// Functional notes
// - stretch clock low until byte handled
// - only the ack pulse of a received byte and the first pulse of a sent byte are stretched
// - each interface answers two port addresses
// - addresses fixed before any bus response
// - primary addresses come from strap level
// - address byte: bits 7..1 address, bit 0 direction
// - firmware masks each address bit per port
// - primary port one decodes 0x20..0x23
// - primary port two decodes 0x24..0x27
// - secondary addresses follow band table
// - first written byte is sub-address
`timescale 1ns/10ps

module ita_target #(
	parameter logic SECONDARY = 1'b0
) (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               nrst,
	// boot state
	input  wire logic               enable,
	input  wire ita_pkg::ita_band_type band,
	input  wire ita_pkg::ita_fw_type   fw_p1,
	input  wire ita_pkg::ita_fw_type   fw_p2,
	// open-drain bus lines
	input  wire logic               scl_i,
	output logic                    scl_o,
	output logic                    scl_oe,
	input  wire logic               sda_i,
	output logic                    sda_o,
	output logic                    sda_oe,
	// received bytes
	output ita_pkg::ita_rx_type     rx,
	output logic                    rx_valid,
	input  wire logic               rx_ready,
	// bytes to send
	output logic                    tx_req,
	input  wire logic               tx_valid,
	input  wire logic [7:0]         tx_data,
	// selection
	output logic                    sel_active,
	output logic                    sel_port,
	output logic                    sel_read
);
	import ita_pkg::*;

	// ********************************************************************
	// line synchronisers: a change counts once stages two and three agree
	// ********************************************************************
	logic [ITA_SYNC_STAGES-1:0] scl_s_q, sda_s_q;
	logic scl_f_q, sda_f_q, scl_f_d, sda_f_d;
	logic scl_rise, scl_fall, start_ev, stop_ev;

	always_comb begin
		scl_f_d = (scl_s_q[1] == scl_s_q[2]) ? scl_s_q[2] : scl_f_q;
		sda_f_d = (sda_s_q[1] == sda_s_q[2]) ? sda_s_q[2] : sda_f_q;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			scl_s_q <= '1;
			sda_s_q <= '1;
			scl_f_q <= 1'b1;
			sda_f_q <= 1'b1;
		end else begin
			scl_s_q <= {scl_s_q[ITA_SYNC_STAGES-2:0], scl_i};
			sda_s_q <= {sda_s_q[ITA_SYNC_STAGES-2:0], sda_i};
			scl_f_q <= scl_f_d;
			sda_f_q <= sda_f_d;
		end
	end

	assign scl_rise = scl_f_d & ~scl_f_q;
	assign scl_fall = ~scl_f_d & scl_f_q;
	assign start_ev = scl_f_q & scl_f_d & sda_f_q & ~sda_f_d;
	assign stop_ev  = scl_f_q & scl_f_d & ~sda_f_q & sda_f_d;

	// ********************************************************************
	// byte engine
	// ********************************************************************
	typedef enum logic [3:0] {
		ST_IDLE, ST_ADDR, ST_AACK_WAIT, ST_AACK, ST_RX, ST_RSTR, ST_RACK,
		ST_TLOAD, ST_TX, ST_TACK, ST_IGNORE
	} ita_state_type;

	ita_state_type state_q, state_d;
	logic [2:0]   cnt_q, cnt_d;
	logic [7:0]   sh_q, sh_d;
	logic         sda_drv_q, sda_drv_d, scl_hold_q, scl_hold_d;
	logic         port_q, port_d, read_q, read_d, sub_q, sub_d, nack_q, nack_d;
	ita_rx_type   rx_q, rx_d;
	logic         rx_valid_q, rx_valid_d;
	logic [7:0]   byte_in;
	ita_addr_type addr_p1, addr_p2;

	assign addr_p1 = ita_port_addr(SECONDARY, 1'b0, band, fw_p1);
	assign addr_p2 = ita_port_addr(SECONDARY, 1'b1, band, fw_p2);
	assign byte_in = {sh_q[6:0], sda_f_d};

	always_comb begin
		state_d    = state_q;
		cnt_d      = cnt_q;
		sh_d       = sh_q;
		sda_drv_d  = sda_drv_q;
		scl_hold_d = scl_hold_q;
		port_d     = port_q;
		read_d     = read_q;
		sub_d      = sub_q;
		nack_d     = nack_q;
		rx_d       = rx_q;
		rx_valid_d = rx_valid_q & ~rx_ready;
		unique case (state_q)
			ST_IDLE, ST_IGNORE: begin
			end
			ST_ADDR: if (scl_rise) begin
				sh_d  = byte_in;
				cnt_d = cnt_q + 3'h1;
				if (cnt_q == ITA_LAST_BIT) begin
					read_d = byte_in[0];
					if (enable && byte_in[7:1] == addr_p1) begin
						port_d  = 1'b0;
						state_d = ST_AACK_WAIT;
					end else if (enable && byte_in[7:1] == addr_p2) begin
						port_d  = 1'b1;
						state_d = ST_AACK_WAIT;
					end else begin
						state_d = ST_IGNORE;
					end
				end
			end
			ST_AACK_WAIT: if (scl_fall) begin
				sda_drv_d = 1'b1;
				sub_d     = 1'b1;
				state_d   = ST_AACK;
			end
			ST_AACK: if (scl_fall) begin
				sda_drv_d = 1'b0;
				cnt_d     = 3'h0;
				state_d   = read_q ? ST_TLOAD : ST_RX;
			end
			ST_RX: if (scl_rise) begin
				sh_d  = byte_in;
				cnt_d = cnt_q + 3'h1;
				if (cnt_q == ITA_LAST_BIT) begin
					rx_d       = '{data: byte_in, port: port_q, sub: sub_q};
					rx_valid_d = 1'b1;
					sub_d      = 1'b0;
					state_d    = ST_RSTR;
				end
			end
			ST_RSTR: begin
				// clock held low while the user side still owns the last byte
				if (scl_fall || scl_hold_q) begin
					if (rx_valid_q && !rx_ready) begin
						scl_hold_d = 1'b1;
					end else begin
						scl_hold_d = 1'b0;
						sda_drv_d  = 1'b1;
						state_d    = ST_RACK;
					end
				end
			end
			ST_RACK: if (scl_fall) begin
				sda_drv_d = 1'b0;
				cnt_d     = 3'h0;
				state_d   = ST_RX;
			end
			ST_TLOAD: begin
				scl_hold_d = 1'b1;
				if (tx_valid) begin
					scl_hold_d = 1'b0;
					sh_d       = tx_data;
					sda_drv_d  = ~tx_data[7];
					cnt_d      = 3'h0;
					state_d    = ST_TX;
				end
			end
			ST_TX: if (scl_fall) begin
				if (cnt_q == ITA_LAST_BIT) begin
					sda_drv_d = 1'b0;
					state_d   = ST_TACK;
				end else begin
					sh_d      = {sh_q[6:0], 1'b0};
					sda_drv_d = ~sh_q[6];
					cnt_d     = cnt_q + 3'h1;
				end
			end
			ST_TACK: begin
				if (scl_rise) begin
					nack_d = sda_f_d;
				end
				if (scl_fall) begin
					state_d = nack_q ? ST_IGNORE : ST_TLOAD;
				end
			end
			default: state_d = ST_IDLE;
		endcase
		// a start or stop always wins: release both lines and resync
		if (start_ev || stop_ev) begin
			state_d    = start_ev ? ST_ADDR : ST_IDLE;
			cnt_d      = 3'h0;
			sda_drv_d  = 1'b0;
			scl_hold_d = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q    <= ST_IDLE;
			cnt_q      <= 3'h0;
			sh_q       <= 8'h00;
			sda_drv_q  <= 1'b0;
			scl_hold_q <= 1'b0;
			port_q     <= 1'b0;
			read_q     <= 1'b0;
			sub_q      <= 1'b0;
			nack_q     <= 1'b0;
			rx_q       <= '0;
			rx_valid_q <= 1'b0;
		end else begin
			state_q    <= state_d;
			cnt_q      <= cnt_d;
			sh_q       <= sh_d;
			sda_drv_q  <= sda_drv_d;
			scl_hold_q <= scl_hold_d;
			port_q     <= port_d;
			read_q     <= read_d;
			sub_q      <= sub_d;
			nack_q     <= nack_d;
			rx_q       <= rx_d;
			rx_valid_q <= rx_valid_d;
		end
	end

	// ********************************************************************
	// outputs
	// ********************************************************************
	// the controller must see the real rise after a stretch; nothing here
	// times its high phase, so short high phases are the controller's fault
	assign scl_o      = 1'b0;
	assign scl_oe     = scl_hold_q;
	assign sda_o      = 1'b0;
	assign sda_oe     = sda_drv_q;
	assign rx         = rx_q;
	assign rx_valid   = rx_valid_q;
	assign tx_req     = (state_q == ST_TLOAD);
	assign sel_active = (state_q != ST_IDLE) && (state_q != ST_ADDR) && (state_q != ST_IGNORE);
	assign sel_port   = port_q;
	assign sel_read   = read_q;
endmodule // ita_target

module ita_top (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               nrst,
	// decoded strap from the converter
	input  wire ita_pkg::ita_band_type address_strap_input,
	input  wire logic               strap_valid,
	input  wire ita_pkg::ita_fw_type [3:0] fw_cfg,
	output logic                    addr_ready,
	// primary_host_port lines
	input  wire logic               pri_scl_i,
	output logic                    pri_scl_o,
	output logic                    pri_scl_oe,
	input  wire logic               pri_sda_i,
	output logic                    pri_sda_o,
	output logic                    pri_sda_oe,
	output ita_pkg::ita_rx_type     pri_rx,
	output logic                    pri_rx_valid,
	input  wire logic               pri_rx_ready,
	output logic                    pri_tx_req,
	input  wire logic               pri_tx_valid,
	input  wire logic [7:0]         pri_tx_data,
	output logic                    pri_sel_active,
	output logic                    pri_sel_port,
	output logic                    pri_sel_read,
	// secondary_host_port lines
	input  wire logic               sec_scl_i,
	output logic                    sec_scl_o,
	output logic                    sec_scl_oe,
	input  wire logic               sec_sda_i,
	output logic                    sec_sda_o,
	output logic                    sec_sda_oe,
	output ita_pkg::ita_rx_type     sec_rx,
	output logic                    sec_rx_valid,
	input  wire logic               sec_rx_ready,
	output logic                    sec_tx_req,
	input  wire logic               sec_tx_valid,
	input  wire logic [7:0]         sec_tx_data,
	output logic                    sec_sel_active,
	output logic                    sec_sel_port,
	output logic                    sec_sel_read
);
	import ita_pkg::*;

	// ********************************************************************
	// boot capture of the strap band
	// ********************************************************************
	ita_band_type band_q, band_d;
	logic         ready_q, ready_d;

	always_comb begin
		band_d  = band_q;
		ready_d = ready_q;
		if (strap_valid && !ready_q) begin
			band_d  = address_strap_input;
			ready_d = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			band_q  <= ITA_BAND_RESET;
			ready_q <= 1'b0;
		end else begin
			band_q  <= band_d;
			ready_q <= ready_d;
		end
	end

	assign addr_ready = ready_q;

	ita_target #(.SECONDARY(1'b0)) u_pri (
		.clk(clk), .nrst(nrst), .enable(ready_q), .band(band_q),
		.fw_p1(fw_cfg[0]), .fw_p2(fw_cfg[1]),
		.scl_i(pri_scl_i), .scl_o(pri_scl_o), .scl_oe(pri_scl_oe),
		.sda_i(pri_sda_i), .sda_o(pri_sda_o), .sda_oe(pri_sda_oe),
		.rx(pri_rx), .rx_valid(pri_rx_valid), .rx_ready(pri_rx_ready),
		.tx_req(pri_tx_req), .tx_valid(pri_tx_valid), .tx_data(pri_tx_data),
		.sel_active(pri_sel_active), .sel_port(pri_sel_port), .sel_read(pri_sel_read)
	);

	ita_target #(.SECONDARY(1'b1)) u_sec (
		.clk(clk), .nrst(nrst), .enable(ready_q), .band(band_q),
		.fw_p1(fw_cfg[2]), .fw_p2(fw_cfg[3]),
		.scl_i(sec_scl_i), .scl_o(sec_scl_o), .scl_oe(sec_scl_oe),
		.sda_i(sec_sda_i), .sda_o(sec_sda_o), .sda_oe(sec_sda_oe),
		.rx(sec_rx), .rx_valid(sec_rx_valid), .rx_ready(sec_rx_ready),
		.tx_req(sec_tx_req), .tx_valid(sec_tx_valid), .tx_data(sec_tx_data),
		.sel_active(sec_sel_active), .sel_port(sec_sel_port), .sel_read(sec_sel_read)
	);
endmodule // ita_top

// file: bench/ita_top_asserts.sv
// concurrent checks on the ports of the two-address i2c target
`timescale 1ns/10ps

module ita_chk (
	// clock and reset
	input wire logic               clk,
	input wire logic               nrst,
	// boot
	input wire logic               strap_valid,
	input wire logic               addr_ready,
	// bus drivers
	input wire logic               pri_scl_o,
	input wire logic               pri_scl_oe,
	input wire logic               pri_sda_oe,
	input wire logic               pri_sda_o,
	input wire logic               sec_scl_o,
	input wire logic               sec_scl_oe,
	input wire logic               sec_sda_oe,
	input wire logic               sec_sda_o,
	// user side
	input wire ita_pkg::ita_rx_type pri_rx,
	input wire logic               pri_rx_valid,
	input wire logic               pri_rx_ready,
	input wire logic               pri_tx_req,
	input wire logic               pri_tx_valid,
	input wire logic               pri_sel_active,
	input wire logic               sec_sel_active
);
	// ****************************************************************
	// properties
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	quiet_boot_a: assert property (!addr_ready |-> !(pri_scl_oe || pri_sda_oe ||
		sec_scl_oe || sec_sda_oe)) else $error("bus driven before boot");
	sel_boot_a: assert property (pri_sel_active || sec_sel_active |-> addr_ready)
		else $error("selected before boot");
	ready_hold_a: assert property (addr_ready |=> addr_ready)
		else $error("address ready dropped");
	ready_cause_a: assert property ($rose(addr_ready) |-> $past(strap_valid))
		else $error("address ready without strap");
	rx_hold_a: assert property (pri_rx_valid && !pri_rx_ready |=>
		pri_rx_valid && $stable(pri_rx)) else $error("byte lost before taken");
	rx_stretch_a: assert property (pri_rx_valid && !pri_rx_ready && pri_scl_oe
		|=> pri_scl_oe) else $error("clock released with byte pending");
	tx_stretch_a: assert property (pri_tx_req && !pri_tx_valid |=> pri_scl_oe)
		else $error("clock not held while byte awaited");
	open_drain_a: assert property (!pri_scl_o && !sec_scl_o && !pri_sda_o && !sec_sda_o)
		else $error("line output not low");

	cover property (pri_rx_valid && pri_scl_oe);
	cover property (pri_tx_req ##1 pri_tx_valid);
	cover property ($rose(addr_ready));
endmodule // ita_chk

// file: bench/ita_ctl.sv
// behavioural i2c bus controller with pull-ups on both lines
`timescale 1ns/10ps

module ita_ctl #(
	parameter int H = 6
) (
	input wire logic clk,
	input wire logic scl_oe,
	input wire logic sda_oe,
	output logic     scl,
	output logic     sda
);
	// ****************************************************************
	// wired-and lines, released level is high
	// ****************************************************************
	logic scl_lo = 1'b0;
	logic sda_lo = 1'b0;
	assign scl = !(scl_lo | scl_oe);
	assign sda = !(sda_lo | sda_oe);

	task automatic gap;
		repeat (H) @(negedge clk);
	endtask

	// high phase is H cycles, shortened from the standard-mode minimum
	task automatic bit_io(input logic b, output logic s);
		int n;
		gap;
		sda_lo = !b;
		gap;
		scl_lo = 1'b0;
		n = 0;
		while (!scl && n < 4000) begin
			@(negedge clk);
			n++;
		end
		gap;
		s = sda;
		scl_lo = 1'b1;
	endtask

	task automatic start;
		sda_lo = 1'b0;
		scl_lo = 1'b0;
		gap;
		sda_lo = 1'b1;
		gap;
		scl_lo = 1'b1;
	endtask

	task automatic stop;
		gap;
		sda_lo = 1'b1;
		gap;
		scl_lo = 1'b0;
		gap;
		sda_lo = 1'b0;
		gap;
	endtask

	// byte out msb first, then the ninth bit; sending ff reads a byte and nacks
	task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
		bit_io(1'b1, s);
		ack = !s;
	endtask
endmodule // ita_ctl

// file: bench/ita_top_bench.sv
// self-checking bench for the strapped two-address i2c target
`timescale 1ns/10ps

module ita_top_bench;
	import ita_pkg::*;
	// ****************************************************************
	// stimulus and wiring
	// ****************************************************************
	logic              clk = 1'b0;
	logic              nrst = 1'b0;
	logic              strap_valid = 1'b0;
	logic              stall = 1'b0;
	ita_band_type      address_strap_input = '0;
	ita_fw_type [3:0]  fw_cfg = '0;
	logic              pri_rx_ready = 1'b0, pri_tx_valid = 1'b0;
	logic              sec_rx_ready = 1'b0, sec_tx_valid = 1'b0;
	logic [7:0]        pri_tx_data = 8'ha5, sec_tx_data = 8'h5a;
	logic              pri_scl_i, pri_sda_i, sec_scl_i, sec_sda_i, addr_ready;
	logic              pri_scl_oe, pri_sda_oe, sec_scl_oe, sec_sda_oe, pri_sel_read;
	logic              pri_rx_valid, sec_rx_valid, pri_tx_req, sec_tx_req;
	ita_rx_type        pri_rx, sec_rx;
	logic              pri_sel_port, pri_sel_active, sec_sel_port, sec_sel_active;
	logic              sec_sel_read;
	logic              pri_tx_seen = 1'b0, sec_tx_seen = 1'b0;
	int                fails = 0, samples_checked = 0;
	logic [6:0]        sec_p1 [4] = '{7'h38, 7'h3f, 7'h4f, 7'h48};
	logic [6:0]        sec_p2 [4] = '{7'h3f, 7'h38, 7'h48, 7'h4f};

	ita_top dut (.*, .pri_scl_o(), .pri_sda_o(), .sec_scl_o(), .sec_sda_o());
	ita_ctl c1 (.clk(clk), .scl_oe(pri_scl_oe), .sda_oe(pri_sda_oe), .scl(pri_scl_i),
		.sda(pri_sda_i));
	ita_ctl c2 (.clk(clk), .scl_oe(sec_scl_oe), .sda_oe(sec_sda_oe), .scl(sec_scl_i),
		.sda(sec_sda_i));

	initial begin
		forever #5 clk = ~clk;
	end

	// consumer answers one cycle late; supplier two, so every read byte is stretched
	always @(negedge clk) begin
		pri_rx_ready <= pri_rx_valid && !stall;
		sec_rx_ready <= sec_rx_valid;
		pri_tx_seen  <= pri_tx_req;
		sec_tx_seen  <= sec_tx_req;
		pri_tx_valid <= pri_tx_req && pri_tx_seen;
		sec_tx_valid <= sec_tx_req && sec_tx_seen;
	end

	// ****************************************************************
	// helpers
	// ****************************************************************
	task automatic check(input logic [9:0] got, input logic [9:0] exp, input string w);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t %s got %h exp %h", $time, w, got, exp);
		end
	endtask

	task automatic probe(input logic sec, input logic [6:0] a, input logic exp);
		logic [7:0] q;
		logic ack;
		if (sec) begin
			c2.start;
			c2.xfer({a, 1'b0}, q, ack);
			c2.stop;
		end else begin
			c1.start;
			c1.xfer({a, 1'b0}, q, ack);
			c1.stop;
		end
		check(10'(ack), 10'(exp), "address ack");
	endtask

	task automatic boot(input logic [1:0] b);
		int n;
		nrst = 1'b0;
		strap_valid = 1'b0;
		address_strap_input = b;
		repeat (3) @(negedge clk);
		nrst = 1'b1;
		probe(1'b0, 7'h20 | 7'(b), 1'b0);
		strap_valid = 1'b1;
		n = 0;
		while (addr_ready !== 1'b1 && n < 20) begin
			@(negedge clk);
			n++;
		end
		check(10'(addr_ready), 10'h1, "ready");
		address_strap_input = ~b;
	endtask

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic t_bands;
		for (int b = 0; b < 4; b++) begin
			boot(2'(b));
			probe(1'b0, 7'h20 | 7'(b), 1'b1);
			probe(1'b0, 7'h24 | 7'(b), 1'b1);
			probe(1'b1, sec_p1[b], 1'b1);
			probe(1'b1, sec_p2[b], 1'b1);
		end
		$display("bands done");
	endtask

	task automatic t_write;
		logic [7:0] q;
		logic a;
		int n;
		stall = 1'b1;
		c1.start;
		c1.xfer(8'h4e, q, a);
		check(10'(a), 10'h1, "write address");
		check(10'({pri_sel_active, pri_sel_port}), 10'h3, "selected port");
		fork
			c1.xfer(8'h3c, q, a);
			begin
				n = 0;
				while (pri_rx_valid !== 1'b1 && n < 1000) begin
					@(negedge clk);
					n++;
				end
				check(pri_rx, {8'h3c, 1'b1, 1'b1}, "sub byte");
				repeat (30) @(negedge clk);
				check(10'(pri_scl_oe), 10'h1, "stretch");
				stall = 1'b0;
			end
		join
		check(10'(a), 10'h1, "sub ack");
		c1.stop;
		c2.start;
		c2.xfer({7'h4f, 1'b0}, q, a);
		check(10'(a), 10'h1, "sec write address");
		c2.xfer(8'h5c, q, a);
		check(sec_rx, {8'h5c, 1'b1, 1'b1}, "sec sub byte");
		check(10'({sec_sel_active, sec_sel_port}), 10'h3, "sec selected port");
		check(10'(a), 10'h1, "sec sub ack");
		c2.stop;
		$display("write done");
	endtask

	task automatic t_read;
		logic [7:0] q;
		logic a;
		c1.start;
		c1.xfer({7'h27, 1'b1}, q, a);
		check(10'(a), 10'h1, "read address");
		check(10'(pri_sel_read), 10'h1, "read bit");
		c1.xfer(8'hff, q, a);
		check(10'(q), 10'ha5, "read data");
		c1.stop;
		c2.start;
		c2.xfer({7'h48, 1'b1}, q, a);
		check(10'(a), 10'h1, "sec read address");
		check(10'(sec_sel_read), 10'h1, "sec read bit");
		c2.xfer(8'hff, q, a);
		check(10'(q), 10'h5a, "sec read data");
		c2.stop;
		$display("read done");
	endtask

	task automatic t_mask;
		fw_cfg[0] = {7'h7f, 7'h11};
		fw_cfg[3] = {7'h01, 7'h00};
		probe(1'b0, 7'h11, 1'b1);
		probe(1'b0, 7'h23, 1'b0);
		probe(1'b1, 7'h4e, 1'b1);
		probe(1'b0, 7'h30, 1'b0);
		fw_cfg = '0;
		$display("mask done");
	endtask

	task automatic close_out;
		$display("checked %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		t_bands;
		t_write;
		t_read;
		t_mask;
		close_out;
	end

	initial begin
		repeat (40000) @(posedge clk);
		fails++;
		$display("[ERR] %0t watchdog expired", $time);
		close_out;
	end
endmodule // ita_top_bench

bind ita_top ita_chk chk (.clk(clk), .nrst(nrst), .strap_valid(strap_valid),
	.addr_ready(addr_ready), .pri_scl_o(pri_scl_o), .pri_scl_oe(pri_scl_oe),
	.pri_sda_oe(pri_sda_oe), .sec_scl_o(sec_scl_o), .sec_scl_oe(sec_scl_oe),
	.sec_sda_oe(sec_sda_oe), .pri_sda_o(pri_sda_o), .sec_sda_o(sec_sda_o),
	.pri_rx(pri_rx), .pri_rx_valid(pri_rx_valid),
	.pri_rx_ready(pri_rx_ready), .pri_tx_req(pri_tx_req), .pri_tx_valid(pri_tx_valid),
	.pri_sel_active(pri_sel_active), .sec_sel_active(sec_sel_active));
